// *** hdl/otpr_pkg.sv ***
// Constants and types shared by both ends of the security register link
package otpr_pkg;
  // Command opcodes
  localparam logic [7:0]  OP_WREN      = 8'h06;
  localparam logic [7:0]  OP_STATUS    = 8'h05;
  localparam logic [7:0]  OP_PROG      = 8'h9B;
  localparam logic [7:0]  OP_READ      = 8'h77;
  // Register geometry
  localparam int          REG_BYTES    = 128;
  localparam int          USER_BYTES   = 64;
  localparam int          BUF_BYTES    = 256;
  localparam logic [6:0]  USER_TOP     = 7'h40;
  localparam logic [7:0]  ERASED       = 8'hFF;
  // Factory portion pattern base, value is arbitrary
  localparam logic [7:0]  FACTORY_SEED = 8'h5A;
  // Frame bit counts: opcode, address end, first data byte, read start
  localparam logic [15:0] BITS_OP      = 16'h0008;
  localparam logic [15:0] BITS_ADDR    = 16'h0020;
  localparam logic [15:0] BITS_DATA    = 16'h0028;
  localparam logic [15:0] BITS_READ    = 16'h0030;
  // Status byte 1 bit positions
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_WEL     = 1;
  // Timing
  localparam int          SYS_MHZ      = 125;
  localparam int          OTPP_US      = 500;
  localparam int          OTPP_CYCLES  = OTPP_US * SYS_MHZ;
  localparam int          HALF_DIV     = 4;
  localparam logic [2:0]  HALF_LOAD    = 3'(HALF_DIV - 1);
  // Device program engine states
  typedef enum logic {
    DS_READY = 1'b0,
    DS_PROG  = 1'b1
  } otpr_dst_t;
  // Host frame sequencer states, Gray along idle-low-high-gap
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LOW  = 2'b01,
    HS_HIGH = 2'b11,
    HS_GAP  = 2'b10
  } otpr_hst_t;
endpackage : otpr_pkg

// *** hdl/otpr_if.sv ***
`timescale 1ns/1ps
// Serial link carrier between host end and device end
interface otpr_if;
  logic sclk;
  logic cs_b;
  logic mosi;
  logic misoOut;
  logic misoOe_b;
  logic miso;
  // Undriven data line floats high through the board pull-up
  assign miso = misoOe_b ? 1'b1 : misoOut;
  modport dev (
    input  sclk,
    input  cs_b,
    input  mosi,
    output misoOut,
    output misoOe_b
  );
  modport host (
    output sclk,
    output cs_b,
    output mosi,
    input  miso
  );
endinterface : otpr_if

// *** hdl/otpr_dev.sv ***
`timescale 1ns/1ps
// Device end: security register command engine on the serial link
module otpr_dev #(
  parameter int OtppCycles = otpr_pkg::OTPP_CYCLES
) (
  otpr_if.dev       link,
  input  wire logic sys_clk,
  input  wire logic rst_b,
  output logic      busy,
  output logic      writeEnable,
  output logic      userLocked
);
  // Link domain state
  logic        first_r;
  logic [15:0] bitCnt_r;
  logic [7:0]  sh_r;
  logic [7:0]  opcode_r;
  logic [6:0]  start_r;
  logic [5:0]  wp_r;
  logic        opDone_r;
  logic        addrDone_r;
  logic        byteDone_r;
  logic        rdPhase_r;
  logic [63:0] mark_r;
  logic [7:0]  buf_r [otpr_pkg::BUF_BYTES];
  logic [1:0]  statS1_r;
  logic [1:0]  statS2_r;
  logic        misoOut_r;
  logic        misoOe_b_r;
  // System domain state
  logic        csS1_r;
  logic        csS2_r;
  logic        csS3_r;
  otpr_pkg::otpr_dst_t st_r;
  logic [31:0] timer_r;
  logic        busy_r;
  logic        wel_r;
  logic        locked_r;
  logic [7:0]  mem_r [otpr_pkg::USER_BYTES];

  // Frame reset: held while deselected so each frame starts clean
  wire         frameRst_b = rst_b & ~link.cs_b;
  wire  [15:0] curCnt     = first_r ? 16'h0000 : bitCnt_r;
  wire  [15:0] newCnt     = curCnt + 16'h0001;
  wire  [7:0]  newSh      = {sh_r[6:0], link.mosi};
  wire         byteEnd    = newCnt[2:0] == 3'h0;
  wire         atOp       = newCnt == otpr_pkg::BITS_OP;
  wire         atAddr     = newCnt == otpr_pkg::BITS_ADDR;
  wire         atData     = newCnt == otpr_pkg::BITS_DATA;
  wire         atRead     = newCnt == otpr_pkg::BITS_READ;
  wire         opValid    = opDone_r & ~first_r;
  wire         linkIdle   = ~statS2_r[otpr_pkg::STAT_BUSY];
  wire         isProgCmd  = opValid & (opcode_r == otpr_pkg::OP_PROG);
  wire         progByte   = isProgCmd & addrDone_r & ~first_r & byteEnd
                            & linkIdle;
  wire         clearMarks = atOp & (newSh == otpr_pkg::OP_PROG) & linkIdle;

  // Frame opens on the first rising edge after select
  always_ff @(posedge link.sclk or negedge frameRst_b) begin
    if (!frameRst_b) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  // Bit counting and command capture, MSB first on rising edges
  always_ff @(posedge link.sclk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_r   <= 16'h0000;
      sh_r       <= 8'h00;
      opcode_r   <= 8'h00;
      start_r    <= 7'h00;
      opDone_r   <= 1'b0;
      addrDone_r <= 1'b0;
      byteDone_r <= 1'b0;
      rdPhase_r  <= 1'b0;
    end else begin
      bitCnt_r   <= newCnt;
      sh_r       <= newSh;
      opDone_r   <= opValid | atOp;
      addrDone_r <= (addrDone_r & ~first_r) | atAddr;
      byteDone_r <= (byteDone_r & ~first_r) | atData;
      // Dummy bytes pass unused; data starts at bit 48
      rdPhase_r  <= (rdPhase_r & ~first_r)
                    | (atRead & opValid
                       & (opcode_r == otpr_pkg::OP_READ));
      if (atOp) begin
        opcode_r <= newSh;
      end
      if (atAddr) begin
        start_r <= newSh[6:0];
      end
    end
  end

  // Buffer write pointer: low six address bits, wraps in user space
  always_ff @(posedge link.sclk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r   <= 6'h00;
      mark_r <= 64'h0000_0000_0000_0000;
    end else begin
      if (atAddr) begin
        wp_r <= newSh[5:0];
      end else if (progByte) begin
        wp_r <= wp_r + 6'h01;
      end
      // Marks record which locations this frame has written
      if (clearMarks) begin
        mark_r <= 64'h0000_0000_0000_0000;
      end else if (progByte) begin
        mark_r[wp_r] <= 1'b1;
      end
    end
  end

  // Shared buffer; later bytes overwrite earlier ones at the same slot
  always_ff @(posedge link.sclk) begin
    if (progByte) begin
      buf_r[{2'b00, wp_r}] <= newSh;
    end
  end
  // Busy and latch levels into the link domain
  always_ff @(posedge link.sclk or negedge rst_b) begin
    if (!rst_b) begin
      statS1_r <= 2'b00;
      statS2_r <= 2'b00;
    end else begin
      statS1_r <= {wel_r, busy_r};
      statS2_r <= statS1_r;
    end
  end

  // Read data selection; user bytes are stable unless programming
  wire  [15:0] dBits    = bitCnt_r - otpr_pkg::BITS_READ;
  wire  [6:0]  rdIdx    = start_r + dBits[9:3];
  wire         rdUser   = rdIdx < otpr_pkg::USER_TOP;
  wire  [7:0]  factByte = otpr_pkg::FACTORY_SEED ^ {1'b0, rdIdx};
  wire  [7:0]  rdByte   = rdUser ? mem_r[rdIdx[5:0]] : factByte;
  wire  [2:0]  rdBitIx  = 3'h7 - dBits[2:0];
  wire  [15:0] stWord   = {6'h00, statS2_r, 8'h00};
  wire  [15:0] sBits    = bitCnt_r - otpr_pkg::BITS_OP;
  wire  [3:0]  stBitIx  = 4'hF - sBits[3:0];
  wire         isStat   = opValid & (opcode_r == otpr_pkg::OP_STATUS);
  wire         drive    = ~first_r & (rdPhase_r | isStat);
  wire         outBit   = rdPhase_r ? rdByte[rdBitIx] : stWord[stBitIx];
  // Output shifts on falling edges; deselect releases it at once
  always_ff @(negedge link.sclk or negedge frameRst_b) begin
    if (!frameRst_b) begin
      misoOut_r  <= 1'b0;
      misoOe_b_r <= 1'b1;
    end else begin
      misoOut_r  <= outBit;
      misoOe_b_r <= ~drive;
    end
  end

  assign link.misoOut  = misoOut_r;
  assign link.misoOe_b = misoOe_b_r;
  // Deselect into the system domain; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      csS1_r <= 1'b1;
      csS2_r <= 1'b1;
      csS3_r <= 1'b1;
    end else begin
      csS1_r <= link.cs_b;
      csS2_r <= csS1_r;
      csS3_r <= csS2_r;
    end
  end
  // Frame end decode; link registers are quiet once the clock stops
  wire frameEnd  = csS2_r & ~csS3_r;
  wire readyEnd  = frameEnd & (st_r == otpr_pkg::DS_READY);
  wire isWrenEnd = opDone_r & (opcode_r == otpr_pkg::OP_WREN)
                   & (bitCnt_r == otpr_pkg::BITS_OP);
  wire isProgEnd = readyEnd & opDone_r & wel_r
                   & (opcode_r == otpr_pkg::OP_PROG);
  wire progGood  = addrDone_r & byteDone_r & (bitCnt_r[2:0] == 3'h0)
                   & ~locked_r;
  wire startProg = isProgEnd & progGood;
  wire abortProg = isProgEnd & ~progGood;
  wire progDone  = (st_r == otpr_pkg::DS_PROG) & (timer_r == 32'h0);

  // Self-timed program engine
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r    <= otpr_pkg::DS_READY;
      timer_r <= 32'h0;
      busy_r  <= 1'b0;
    end else begin
      case (st_r)
        otpr_pkg::DS_READY: begin
          if (startProg) begin
            st_r    <= otpr_pkg::DS_PROG;
            timer_r <= 32'(OtppCycles - 1);
            busy_r  <= 1'b1;
          end
        end
        otpr_pkg::DS_PROG: begin
          if (progDone) begin
            st_r   <= otpr_pkg::DS_READY;
            busy_r <= 1'b0;
          end else begin
            timer_r <= timer_r - 32'h1;
          end
        end
        default: begin
          st_r   <= otpr_pkg::DS_READY;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // Latch drops at program start or abort; lock follows completion
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wel_r    <= 1'b0;
      locked_r <= 1'b0;
    end else begin
      if (startProg | abortProg) begin
        wel_r <= 1'b0;
      end else if (readyEnd & isWrenEnd) begin
        wel_r <= 1'b1;
      end
      if (progDone) begin
        locked_r <= 1'b1;
      end
    end
  end

  // User array, one entry per location; factory part is not writable
  genvar gi;
  generate
    for (gi = 0; gi < otpr_pkg::USER_BYTES; gi++) begin : g_user
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          mem_r[gi] <= otpr_pkg::ERASED;
        end else if (progDone & mark_r[gi]) begin
          mem_r[gi] <= buf_r[gi];
        end
      end
    end
  endgenerate
  assign busy        = busy_r;
  assign writeEnable = wel_r;
  assign userLocked  = locked_r;
endmodule : otpr_dev

// *** hdl/otpr_host.sv ***
`timescale 1ns/1ps
// Host end: frames commands onto the link from the system clock
module otpr_host (
  otpr_if.host       link,
  input  wire logic  sys_clk,
  input  wire logic  rst_b,
  input  wire logic  cmdValid,
  input  wire logic [31:0] cmdHdr,
  input  wire logic [2:0]  cmdHdrBytes,
  input  wire logic [15:0] cmdBits,
  input  wire logic [7:0]  txData,
  output logic       cmdReady,
  output logic       txTake,
  output logic       rxValid,
  output logic [7:0] rxByte,
  output logic       done
);

  otpr_pkg::otpr_hst_t st_r;
  logic [2:0]  div_r;
  logic [15:0] bitsLeft_r;
  logic [31:0] sh_r;
  logic [2:0]  hdrLeft_r;
  logic [2:0]  bitIx_r;
  logic [7:0]  rxSh_r;
  logic        misoS1_r;
  logic        misoS2_r;
  logic        sclk_r;
  logic        cs_b_r;
  logic        mosi_r;
  logic        cmdReady_r;
  logic        txTake_r;
  logic        rxValid_r;
  logic [7:0]  rxByte_r;
  logic        done_r;

  // Step decode for the divided clock
  wire       halfEnd  = div_r == 3'h0;
  wire       lastBit  = bitsLeft_r == 16'h0001;
  wire       byteLast = bitIx_r == 3'h7;
  wire       hdrMore  = hdrLeft_r > 3'h1;
  wire [7:0] rxNext   = {rxSh_r[6:0], misoS2_r};
  wire       accept   = cmdValid & cmdReady_r;

  // Returning data line synchronised; half period covers the delay
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      misoS1_r <= 1'b1;
      misoS2_r <= 1'b1;
    end else begin
      misoS1_r <= link.miso;
      misoS2_r <= misoS1_r;
    end
  end

  // Frame sequencer; mode 0, host shifts on falling, samples at fall
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r       <= otpr_pkg::HS_IDLE;
      div_r      <= 3'h0;
      bitsLeft_r <= 16'h0000;
      sh_r       <= 32'h0;
      hdrLeft_r  <= 3'h0;
      bitIx_r    <= 3'h0;
      rxSh_r     <= 8'h00;
      sclk_r     <= 1'b0;
      cs_b_r     <= 1'b1;
      mosi_r     <= 1'b0;
      cmdReady_r <= 1'b1;
      txTake_r   <= 1'b0;
      rxValid_r  <= 1'b0;
      rxByte_r   <= 8'h00;
      done_r     <= 1'b0;
    end else begin
      txTake_r  <= 1'b0;
      rxValid_r <= 1'b0;
      done_r    <= 1'b0;
      div_r     <= halfEnd ? otpr_pkg::HALF_LOAD : div_r - 3'h1;
      case (st_r)
        otpr_pkg::HS_IDLE: begin
          if (accept) begin
            st_r       <= otpr_pkg::HS_LOW;
            div_r      <= otpr_pkg::HALF_LOAD;
            cs_b_r     <= 1'b0;
            cmdReady_r <= 1'b0;
            sh_r       <= cmdHdr;
            mosi_r     <= cmdHdr[31];
            bitsLeft_r <= cmdBits;
            hdrLeft_r  <= cmdHdrBytes;
            bitIx_r    <= 3'h0;
          end
        end
        otpr_pkg::HS_LOW: begin
          if (halfEnd) begin
            sclk_r <= 1'b1;
            st_r   <= otpr_pkg::HS_HIGH;
          end
        end
        otpr_pkg::HS_HIGH: begin
          if (halfEnd) begin
            sclk_r     <= 1'b0;
            rxSh_r     <= rxNext;
            bitIx_r    <= bitIx_r + 3'h1;
            bitsLeft_r <= bitsLeft_r - 16'h0001;
            rxValid_r  <= byteLast;
            if (byteLast) begin
              rxByte_r <= rxNext;
            end
            if (lastBit) begin
              st_r <= otpr_pkg::HS_GAP;
            end else begin
              st_r <= otpr_pkg::HS_LOW;
              // Header first, then one user byte per boundary
              if (byteLast & ~hdrMore) begin
                sh_r     <= {txData, 24'h000000};
                mosi_r   <= txData[7];
                txTake_r <= 1'b1;
              end else begin
                sh_r   <= {sh_r[30:0], 1'b0};
                mosi_r <= sh_r[30];
              end
              if (byteLast & hdrMore) begin
                hdrLeft_r <= hdrLeft_r - 3'h1;
              end
            end
          end
        end
        otpr_pkg::HS_GAP: begin
          // Deselect, then hold off one half period before next frame
          if (halfEnd & ~cs_b_r) begin
            cs_b_r <= 1'b1;
          end else if (halfEnd) begin
            st_r       <= otpr_pkg::HS_IDLE;
            cmdReady_r <= 1'b1;
            done_r     <= 1'b1;
          end
        end
        default: begin
          st_r   <= otpr_pkg::HS_IDLE;
          cs_b_r <= 1'b1;
          sclk_r <= 1'b0;
        end
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_b = cs_b_r;
  assign link.mosi = mosi_r;
  assign cmdReady  = cmdReady_r;
  assign txTake    = txTake_r;
  assign rxValid   = rxValid_r;
  assign rxByte    = rxByte_r;
  assign done      = done_r;

endmodule : otpr_host

// *** verif/otpr_monitor.sv ***
// Checker for the serial link and program status of the security register
`timescale 1ns/1ps
module otpr_monitor #(
  parameter int OtppCycles = otpr_pkg::OTPP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  input wire logic misoOut,
  input wire logic misoOe_b,
  input wire logic miso,
  input wire logic busy,
  input wire logic writeEnable,
  input wire logic userLocked
);
  int busyCnt_r;
  int busyCnt_nxt;

  // Length of the current busy stretch, cleared while ready
  assign busyCnt_nxt = busy ? busyCnt_r + 1 : 0;

  // Counter lets the program time be judged without long repetitions
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busyCnt_r <= 0;
    end else begin
      busyCnt_r <= busyCnt_nxt;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // Link framing and bit timing
  a_deselect_releases: assert property (cs_b |-> misoOe_b)
    else $error("data line driven while deselected");
  a_clock_idles_low: assert property (cs_b |-> !sclk)
    else $error("serial clock not low outside a frame");
  a_out_moves_fall: assert property (
    (sclk && $past(sclk)) |-> $stable(misoOut))
    else $error("device output changed while clock high");
  a_in_steady_high: assert property (
    (sclk && $past(sclk)) |-> $stable(mosi))
    else $error("host data changed while clock high");
  // Program engine
  a_prog_on_deselect: assert property (
    $rose(busy) |-> (cs_b && $past(cs_b)))
    else $error("programming began inside a frame");
  a_latch_off_busy: assert property (
    (busy && $past(busy)) |-> !writeEnable)
    else $error("write enable still set while programming");
  a_prog_duration: assert property (
    $fell(busy) |->
      (busyCnt_r >= OtppCycles - 1 && busyCnt_r <= OtppCycles + 1))
    else $error("program time differs from the set duration");
  a_locked_after_prog: assert property ($fell(busy) |-> userLocked)
    else $error("user portion not locked after programming");
  a_lock_is_final: assert property (1'b1 |-> !$fell(userLocked))
    else $error("user lock was released");
  a_no_reprogram: assert property ($rose(busy) |-> !userLocked)
    else $error("locked user portion programmed again");

  // Main scenarios reached
  cover property ($rose(busy));
  cover property ($fell(writeEnable) && !busy);
  cover property ($fell(misoOe_b));
  cover property (!misoOe_b && !miso);
endmodule : otpr_monitor

// *** verif/test_otp_security_register_access.sv ***
// Bench joining host and device ends over the security register link
`timescale 1ns/1ps
module test_otp_security_register_access;
  localparam int          Otpp       = 600;
  localparam logic [15:0] BadBits[3] = '{16'h002C, 16'h0020, 16'h0018};
  logic        sys_clk;
  logic        rst_b;
  logic        cmdValid;
  logic [31:0] cmdHdr;
  logic [2:0]  cmdHdrBytes;
  logic [15:0] cmdBits;
  logic [7:0]  txData;
  logic        cmdReady;
  logic        txTake;
  logic        rxValid;
  logic [7:0]  rxByte;
  logic        done;
  logic        busy;
  logic        writeEnable;
  logic        userLocked;
  logic        sawBusy;
  logic [7:0]  txq[$];
  logic [7:0]  rx[$];
  logic [7:0]  mem[128];
  int          n_fail;
  int          total_checks;
  int          pollLeft;

  otpr_if link ();
  otpr_host u_otpr_host (
    .link(link), .sys_clk(sys_clk), .rst_b(rst_b), .cmdValid(cmdValid),
    .cmdHdr(cmdHdr), .cmdHdrBytes(cmdHdrBytes), .cmdBits(cmdBits),
    .txData(txData), .cmdReady(cmdReady), .txTake(txTake),
    .rxValid(rxValid), .rxByte(rxByte), .done(done)
  );
  otpr_dev #(.OtppCycles(Otpp)) u_otpr_dev (
    .link(link), .sys_clk(sys_clk), .rst_b(rst_b), .busy(busy),
    .writeEnable(writeEnable), .userLocked(userLocked)
  );
  otpr_monitor #(.OtppCycles(Otpp)) u_otpr_monitor (
    .sys_clk(sys_clk), .rst_b(rst_b), .sclk(link.sclk), .cs_b(link.cs_b),
    .mosi(link.mosi), .misoOut(link.misoOut), .misoOe_b(link.misoOe_b),
    .miso(link.miso), .busy(busy), .writeEnable(writeEnable),
    .userLocked(userLocked)
  );

  // System clock, 8 ns
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Feed payload bytes and gather received bytes; old values seen at edge
  always @(posedge sys_clk) begin
    if (rxValid === 1'b1) begin
      rx.push_back(rxByte);
    end
    if (busy === 1'b1) begin
      sawBusy <= 1'b1;
    end
    if (txTake === 1'b1 && txq.size() > 0) begin
      void'(txq.pop_front());
      txData <= (txq.size() > 0) ? txq[0] : 8'h00;
    end
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One whole frame; request held only for the edge that takes it
  task automatic frame(input logic [31:0] hdr, input logic [2:0] nb,
                       input logic [15:0] bits);
    int t;
    rx.delete();
    @(posedge sys_clk);
    txData      <= (txq.size() > 0) ? txq[0] : 8'h00;
    cmdHdr      <= hdr;
    cmdHdrBytes <= nb;
    cmdBits     <= bits;
    cmdValid    <= 1'b1;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    @(posedge sys_clk);
    chk("ready in frame", {7'h00, cmdReady}, 8'h00);
    t = 0;
    while (done !== 1'b1 && t < 4000) begin
      @(posedge sys_clk);
      t++;
    end
    if (t >= 4000) begin
      n_fail++;
      $display("[FAIL] frame end never came");
      finish_test();
    end
    chk("ready after frame", {7'h00, cmdReady}, 8'h01);
  endtask : frame

  task automatic status(input logic [7:0] exp);
    frame({otpr_pkg::OP_STATUS, 24'h000000}, 3'h1, 16'h0018);
    chk("idle data line", rx[0], 8'hFF);
    chk("status byte 1", rx[1], exp);
    chk("status byte 2", rx[2], 8'h00);
    chk("latch level", {7'h00, writeEnable}, {7'h00, exp[1]});
  endtask : status

  task automatic wren();
    frame({otpr_pkg::OP_WREN, 24'h000000}, 3'h1, 16'h0008);
  endtask : wren

  // Read n bytes, then drop select three bits into the next byte
  task automatic rd(input logic [6:0] a, input int n);
    txq = {8'h00, 8'h00};
    frame({otpr_pkg::OP_READ, 17'h00000, a}, 3'h4, 16'(48 + 8 * n + 3));
    for (int k = 0; k < n; k++) begin
      chk("read data", rx[6 + k], mem[7'(a + k)]);
    end
  endtask : rd

  task automatic prog(input logic [23:0] a, input logic [15:0] bits);
    frame({otpr_pkg::OP_PROG, a}, 3'h4, bits);
  endtask : prog

  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    finish_test();
  end

  initial begin
    // Start high so the drop at 1 ns is a clean edge for every reset
    rst_b        = 1'b1;
    cmdValid     = 1'b0;
    cmdHdr       = 32'h00000000;
    cmdHdrBytes  = 3'h1;
    cmdBits      = 16'h0008;
    txData       = 8'h00;
    sawBusy      = 1'b0;
    n_fail       = 0;
    total_checks = 0;
    // Expected contents: user bytes erased, factory bytes patterned
    for (int i = 0; i < 128; i++) begin
      mem[i] = (i < otpr_pkg::USER_BYTES) ? otpr_pkg::ERASED
                                          : otpr_pkg::FACTORY_SEED ^ 8'(i);
    end
    #1 rst_b = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    status(8'h00);
    rd(7'h7E, 4);
    // Program without the latch must be refused
    txq = {8'h11};
    prog(24'h000000, 16'h0028);
    status(8'h00);
    // Malformed frames: partial last byte, no data byte, short address
    foreach (BadBits[i]) begin
      wren();
      status(8'h02);
      txq = {8'h22, 8'h33};
      prog(24'h000000, BadBits[i]);
      status(8'h00);
    end
    chk("busy seen", {7'h00, sawBusy}, 8'h00);
    chk("user lock", {7'h00, userLocked}, 8'h00);
    // Wrapping program, upper address bits set to junk
    wren();
    txq = {8'hA1, 8'hA2, 8'hA3};
    prog(24'hFFFF3E, 16'h0038);
    status(8'h01);
    pollLeft = 20;
    while (rx[1] !== 8'h00 && pollLeft > 0) begin
      frame({otpr_pkg::OP_STATUS, 24'h000000}, 3'h1, 16'h0018);
      pollLeft--;
    end
    chk("ready status", rx[1], 8'h00);
    chk("busy seen", {7'h00, sawBusy}, 8'h01);
    chk("user lock", {7'h00, userLocked}, 8'h01);
    mem[7'h3E] = 8'hA1;
    mem[7'h3F] = 8'hA2;
    mem[7'h00] = 8'hA3;
    rd(7'h3C, 5);
    rd(7'h7F, 3);
    // A second program of the user portion aborts and changes nothing
    wren();
    status(8'h02);
    txq = {8'h00};
    prog(24'h000001, 16'h0028);
    status(8'h00);
    rd(7'h00, 2);
    finish_test();
  end
endmodule : test_otp_security_register_access
